// file: dv/sea_assertions.sv
// Port-level checks on the serial EEPROM access master
`timescale 1ns/1ps
`default_nettype none
module sea_assertions
  import sea_pkg::*;
(
  // Clock and reset
  input wire logic                   mclk,
  input wire logic                   sys_rst,
  // Requests
  input wire logic                   vendor_write_request,
  input wire logic                   vendor_read_request,
  input wire logic                   slave_index,
  input wire logic                   mode_cpol,
  // Status and count outputs
  input wire logic                   busy,
  input wire logic                   done,
  input wire logic [7:0]             control_count_data,
  input wire logic                   control_in_buffer_we,
  input wire logic                   control_count_high_we,
  input wire logic                   control_count_low_we,
  // Serial link
  input wire logic                   spi_sclk,
  input wire logic                   spi_mosi,
  input wire logic [SLAVE_COUNT-1:0] spi_cs_n
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);

  // ----------------------------------------------------------------
  // Rising serial clock edges within the current frame
  // ----------------------------------------------------------------
  logic [7:0] rise_cnt_reg;
  always_ff @(posedge mclk) begin
    if (sys_rst || $fell(&spi_cs_n)) begin
      rise_cnt_reg <= 8'h00;
    end else if ($rose(spi_sclk) && !(&spi_cs_n)) begin
      rise_cnt_reg <= rise_cnt_reg + 8'h01;
    end
  end

  sequence s_quiet;
    $stable(spi_sclk) [*8];
  endsequence
  sequence s_arm;
    control_count_high_we && control_count_data == 8'h00
      ##1 control_count_low_we && control_count_data == 8'h01 && done;
  endsequence

  property p_accept;
    !busy && (vendor_write_request || vendor_read_request)
      |=> busy && spi_cs_n == ($past(slave_index) ? 2'b01 : 2'b10);
  endproperty
  a_accept: assert property (p_accept) else $error("select not taken after accept");
  property p_one_sel;
    spi_cs_n != 2'b00;
  endproperty
  a_one_sel: assert property (p_one_sel) else $error("two selects low");
  property p_idle_cs;
    !busy |-> spi_cs_n == 2'b11;
  endproperty
  a_idle_cs: assert property (p_idle_cs) else $error("select low while idle");
  property p_sclk_idle;
    spi_cs_n == 2'b11 && $past(spi_cs_n) == 2'b11 && $stable(mode_cpol) && !$past(sys_rst)
      |-> spi_sclk == mode_cpol;
  endproperty
  a_sclk_idle: assert property (p_sclk_idle) else $error("idle clock level wrong");
  property p_mosi_hold;
    spi_cs_n != 2'b11 && $past(spi_cs_n) != 2'b11 && spi_sclk && $past(spi_sclk) |-> $stable(spi_mosi);
  endproperty
  a_mosi_hold: assert property (p_mosi_hold) else $error("data out moved while clock high");
  property p_cs_setup;
    $fell(&spi_cs_n) |-> s_quiet;
  endproperty
  a_cs_setup: assert property (p_cs_setup) else $error("clock moved at select");
  property p_cs_gap;
    $rose(&spi_cs_n) |-> (&spi_cs_n) [*8];
  endproperty
  a_cs_gap: assert property (p_cs_gap) else $error("deselect gap too short");
  property p_high_half;
    $rose(spi_sclk) && spi_cs_n != 2'b11 |-> spi_sclk [*8];
  endproperty
  a_high_half: assert property (p_high_half) else $error("clock high half too short");
  property p_whole_bytes;
    $rose(&spi_cs_n) |-> rise_cnt_reg[2:0] == 3'h0 && rise_cnt_reg != 8'h00;
  endproperty
  a_whole_bytes: assert property (p_whole_bytes) else $error("frame not whole bytes");
  property p_arm;
    control_in_buffer_we |=> s_arm;
  endproperty
  a_arm: assert property (p_arm) else $error("count arming order wrong");
  property p_done;
    done && !vendor_write_request && !vendor_read_request |-> spi_cs_n == 2'b11 ##1 !busy;
  endproperty
  a_done: assert property (p_done) else $error("done with select low or busy kept");
endmodule

bind sea_master sea_assertions u_sea_assertions (.mclk, .sys_rst, .vendor_write_request,
  .vendor_read_request, .slave_index, .mode_cpol, .busy, .done, .control_count_data,
  .control_in_buffer_we, .control_count_high_we, .control_count_low_we, .spi_sclk, .spi_mosi, .spi_cs_n);
`default_nettype wire

// file: dv/sea_eeprom_model.sv
// Behavioural serial EEPROM slave, 2048 bytes
`timescale 1ns/1ps
`default_nettype none
module sea_eeprom_model #(
  parameter int WR_NS = 20000
) (
  // Serial link
  input  wire logic sclk,
  input  wire logic mosi,
  input  wire logic cs_n,
  output logic      miso
);
  logic [7:0]  mem [0:2047];
  logic [7:0]  op;
  logic [7:0]  rx;
  logic [7:0]  tx = 8'h00;
  logic [10:0] addr;
  logic        wel = 1'b0;
  logic        wip = 1'b0;
  logic        wr_seen = 1'b0;
  logic        out_bit = 1'b0;
  int          cnt = 0;
  int          n_busy = 0;
  int          n_pad = 0;

  initial begin
    foreach (mem[i]) mem[i] = 8'hff;
  end
  // Released line shows the inverse of the last bit
  assign miso = cs_n ? ~out_bit : out_bit;
  always @(negedge cs_n) cnt = 0;
  always @(posedge sclk) begin
    if (!cs_n) begin
      rx = {rx[6:0], mosi};
      cnt = cnt + 1;
      if (cnt % 8 == 0) begin
        case (cnt / 8)
          1: op = rx;
          2: begin
            addr[10:8] = rx[2:0];
            if (rx[7:3] != 5'h00) n_pad++;
          end
          3: addr[7:0] = rx;
          default: if (op == 8'h02 && wel) begin
            mem[addr] = rx;
            addr = addr + 11'h001;
            wr_seen = 1'b1;
          end
        endcase
        if (op == 8'h05 && wip) n_busy++;
        // Data read during a write cycle comes back corrupted
        tx = (op == 8'h05) ? {7'h00, wip} : (wip ? ~mem[addr] : mem[addr]);
      end
    end
  end
  always @(negedge sclk) begin
    if (!cs_n) out_bit = tx[7 - (cnt % 8)];
  end
  always @(posedge cs_n) begin
    if (op == 8'h06 && cnt == 8) wel = 1'b1;
    if (wr_seen) begin
      wel = 1'b0;
      wr_seen = 1'b0;
      wip = 1'b1;
      wip <= #WR_NS 1'b0;
    end
  end
endmodule
`default_nettype wire

// file: dv/sea_master_test.sv
// Self-checking bench for the serial EEPROM access master
`timescale 1ns/1ps
`default_nettype none
module sea_master_test
  import sea_pkg::*;
;
  localparam int CYC_MAX = 90000;
  logic                     mclk = 1'b0;
  logic                     sys_rst = 1'b1;
  logic                     vendor_write_request = 1'b0;
  logic                     vendor_read_request = 1'b0;
  logic [8*SETUP_BYTES-1:0] setup_packet_buffer = '0;
  logic                     slave_index = 1'b0;
  logic                     mode_cpol = 1'b0;
  logic                     busy;
  logic                     done;
  logic [7:0]               control_in_buffer;
  logic                     control_in_buffer_we;
  logic [7:0]               control_count_data;
  logic                     control_count_high_we;
  logic                     control_count_low_we;
  logic                     spi_sclk;
  logic                     spi_mosi;
  logic [SLAVE_COUNT-1:0]   spi_cs_n;
  logic                     spi_miso;
  logic                     miso0;
  logic                     miso1;
  int                       err_total = 0;
  int                       n_tests = 0;
  int                       cyc_count = 0;

  always #4 mclk = ~mclk;
  assign spi_miso = spi_cs_n[0] ? miso1 : miso0;

  sea_master u_dut (.mclk(mclk), .sys_rst(sys_rst), .vendor_write_request(vendor_write_request),
    .vendor_read_request(vendor_read_request), .setup_packet_buffer(setup_packet_buffer),
    .slave_index(slave_index), .mode_cpol(mode_cpol), .busy(busy), .done(done),
    .control_in_buffer(control_in_buffer), .control_in_buffer_we(control_in_buffer_we),
    .control_count_data(control_count_data), .control_count_high_we(control_count_high_we),
    .control_count_low_we(control_count_low_we), .spi_sclk(spi_sclk), .spi_mosi(spi_mosi),
    .spi_cs_n(spi_cs_n), .spi_miso(spi_miso));
  sea_eeprom_model u_ee0 (.sclk(spi_sclk), .mosi(spi_mosi), .cs_n(spi_cs_n[0]), .miso(miso0));
  sea_eeprom_model u_ee1 (.sclk(spi_sclk), .mosi(spi_mosi), .cs_n(spi_cs_n[1]), .miso(miso1));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic send_req(input logic wr, input logic sl, input logic cp, input logic [10:0] a, input logic [7:0] d);
    @(posedge mclk);
    slave_index <= sl;
    mode_cpol <= cp;
    setup_packet_buffer <= {24'h776655, d, 5'h15, a[10:8], a[7:0], 16'h3311};
    // Idle clock settles to the new mode before select can fall
    repeat (3) @(posedge mclk);
    vendor_write_request <= wr;
    vendor_read_request <= !wr;
    @(posedge mclk);
    vendor_write_request <= 1'b0;
    vendor_read_request <= 1'b0;
  endtask

  // Waits for done, gathering read data and count pulses
  task automatic run_to_done(output logic [7:0] rd, output logic [7:0] n_arm);
    rd = 8'hxx;
    n_arm = 8'h00;
    for (int i = 0; i < 30000 && done !== 1'b1; i++) begin
      @(negedge mclk);
      if (control_in_buffer_we === 1'b1) rd = control_in_buffer;
      n_arm = n_arm + {7'h00, control_in_buffer_we === 1'b1} + {7'h00, control_count_high_we === 1'b1};
      n_arm = n_arm + {7'h00, control_count_low_we === 1'b1};
      if (control_count_high_we === 1'b1) chk8("count_high", 8'h00, control_count_data);
      if (control_count_low_we === 1'b1) chk8("count_low", 8'h01, control_count_data);
    end
    chk8("done", 8'h01, {7'h00, done});
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_write(input logic sl, input logic cp, input logic [10:0] a, input logic [7:0] d);
    logic [7:0] rd;
    logic [7:0] n;
    send_req(1'b1, sl, cp, a, d);
    repeat (100) @(posedge mclk);
    vendor_read_request <= 1'b1;
    @(posedge mclk);
    vendor_read_request <= 1'b0;
    run_to_done(rd, n);
    chk8("arm_pulses_write", 8'h00, n);
    repeat (3) @(negedge mclk);
    chk8("busy_after_write", 8'h00, {7'h00, busy});
    chk8("mem_written", d, sl ? u_ee1.mem[a] : u_ee0.mem[a]);
    chk8("other_mem", 8'hff, sl ? u_ee0.mem[a] : u_ee1.mem[a]);
  endtask

  task automatic t_read(input logic sl, input logic cp, input logic [10:0] a, input logic [7:0] exp);
    logic [7:0] rd;
    logic [7:0] n;
    send_req(1'b0, sl, cp, a, 8'h99);
    run_to_done(rd, n);
    chk8("read_data", exp, rd);
    chk8("arm_pulses_read", 8'h03, n);
  endtask

  always @(posedge mclk) begin
    cyc_count <= cyc_count + 1;
    if (cyc_count == CYC_MAX) begin
      err_total++;
      print_verdict();
    end
  end

  initial begin
    repeat (16) @(posedge mclk);
    sys_rst <= 1'b0;
    t_write(1'b0, 1'b0, 11'h7ff, 8'ha5);
    t_read(1'b0, 1'b1, 11'h7ff, 8'ha5);
    chk8("busy_status_seen", 8'h01, {7'h00, u_ee0.n_busy != 0});
    t_write(1'b1, 1'b1, 11'h123, 8'h3c);
    t_read(1'b1, 1'b0, 11'h123, 8'h3c);
    t_read(1'b0, 1'b0, 11'h000, 8'hff);
    chk8("addr_high_pad", 8'h00, 8'(u_ee0.n_pad + u_ee1.n_pad));
    print_verdict();
  end
endmodule
`default_nettype wire

// file: rtl/sea_master.sv
// Serial EEPROM access master: byte write and byte read sequencer
//
// Function
// (R1) Bytes shift MSB first, eight clocks exchange
// (R2) Select held low during whole transfer
// (R3) Slave floats output and ignores clock deselected; the test model drives the inverse of its last bit
// (R4) Sample on rising edge; idle level per mode
// (R5) One select output per attached slave
// (R6) Write enable 0x06 then select cycled
// (R7) Write: 0x02, address high, low, data
// (R8) Select rises after data, starting write
// (R9) Slave increments address for burst bytes
// (R10) Poll status until busy bit clears
// (R11) Cycle select, read opcode, address, data
// (R12) Data to buffer, count high then low
// (R13) Eleven-bit address sent high byte first
// (R14) Address and data from setup packet bytes
// (R15) Status read opcode 0x05, status follows
// (R16) Read opcode 0x03, address, data returned
// (R17) Divided clock; accept only when idle
`timescale 1ns/1ps
`default_nettype none
module sea_master
  import sea_pkg::*;
(
  // Clock and reset
  input  wire logic                     mclk,
  input  wire logic                     sys_rst,
  // Request front end
  input  wire logic                     vendor_write_request,
  input  wire logic                     vendor_read_request,
  input  wire logic [8*SETUP_BYTES-1:0] setup_packet_buffer,
  input  wire logic                     slave_index,
  input  wire logic                     mode_cpol,
  // Status
  output logic                          busy,
  output logic                          done,
  // Control-IN buffer and byte count
  output logic [7:0]                    control_in_buffer,
  output logic                          control_in_buffer_we,
  output logic [7:0]                    control_count_data,
  output logic                          control_count_high_we,
  output logic                          control_count_low_we,
  // Serial link
  output logic                          spi_sclk,
  output logic                          spi_mosi,
  output logic [SLAVE_COUNT-1:0]        spi_cs_n,
  input  wire logic                     spi_miso
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------

  // Byte to send for a given position within a frame
  function automatic logic [7:0] frame_byte(
    input logic                    op_read,
    input logic                    frame,
    input logic [1:0]              idx,
    input logic [ARRAY_ADDR_W-1:0] addr,
    input logic [7:0]              wdata
  );
    logic [7:0] b;
    b = DUMMY_BYTE;
    if (!frame) begin
      if (idx == 2'd0) begin
        b = op_read ? OP_READ_STATUS : OP_WRITE_ENABLE; // (R6) (R15)
      end
    end else begin
      case (idx)
        2'd0: begin
          b = op_read ? OP_READ : OP_WRITE; // (R7) (R16)
        end
        2'd1: begin
          b = 8'(addr[ARRAY_ADDR_W-1:8]); // (R13)
        end
        2'd2: begin
          b = addr[7:0]; // (R13)
        end
        default: begin
          b = op_read ? DUMMY_BYTE : wdata;
        end
      endcase
    end
    return b;
  endfunction

  // Setup packet byte by index
  function automatic logic [7:0] setup_byte(
    input logic [8*SETUP_BYTES-1:0] pkt,
    input int                       n
  );
    return pkt[8*n +: 8];
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    sea_state_e              state;
    logic                    op_read;
    logic                    frame;
    logic [1:0]              idx;
    logic                    slave;
    logic                    cpol;
    logic [ARRAY_ADDR_W-1:0] addr;
    logic [7:0]              wdata;
    logic [CNT_W-1:0]        cnt;
    logic                    selected;
    logic                    start;
    logic [7:0]              tx;
    logic                    miso_meta;
    logic                    miso_sync;
    logic [7:0]              buf_data;
    logic                    buf_we;
    logic [7:0]              cnt_data;
    logic                    cnt_hi_we;
    logic                    cnt_lo_we;
    logic                    done;
    logic [SLAVE_COUNT-1:0]  cs_n;
  } sea_master_s;

  sea_master_s r_reg;
  sea_master_s r_next;

  logic       sh_done;
  logic [7:0] sh_rx;

  // ----------------------------------------------------------------
  // Byte shifter
  // ----------------------------------------------------------------
  sea_shift u_shift (
    .mclk      (mclk),
    .sys_rst   (sys_rst),
    .start     (r_reg.start),
    .tx_byte   (r_reg.tx),
    .cpol      (r_next.cpol),
    .miso_sync (r_reg.miso_sync),
    .sclk      (spi_sclk),
    .mosi      (spi_mosi),
    .rx_byte   (sh_rx),
    .done      (sh_done)
  );

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    r_next           = r_reg;
    r_next.start     = 1'b0;
    r_next.buf_we    = 1'b0;
    r_next.cnt_hi_we = 1'b0;
    r_next.cnt_lo_we = 1'b0;
    r_next.done      = 1'b0;
    // Link input passes two flip-flops
    r_next.miso_meta = spi_miso;
    r_next.miso_sync = r_reg.miso_meta;

    case (r_reg.state)
      ST_IDLE: begin
        // Idle clock level tracks the mode; change it before a request, not with it (R4)
        r_next.cpol = mode_cpol;
        // New work only once the previous frame has closed (R17)
        if (vendor_write_request || vendor_read_request) begin
          r_next.op_read  = !vendor_write_request;
          r_next.frame    = 1'b0;
          r_next.idx      = 2'd0;
          r_next.slave    = slave_index;
          // Address and data from the setup packet; bits above the array dropped (R14) (R13)
          r_next.addr     = ARRAY_ADDR_W'({setup_byte(setup_packet_buffer, SETUP_ADDR_HI_IDX),
                                           setup_byte(setup_packet_buffer, SETUP_ADDR_LO_IDX)});
          r_next.wdata    = setup_byte(setup_packet_buffer, SETUP_DATA_IDX);
          r_next.cnt      = '0;
          r_next.selected = 1'b1;
          r_next.state    = ST_SEL;
        end
      end

      ST_SEL: begin
        // Select low ahead of the first clock edge (R2)
        if (r_reg.cnt == CS_GAP_CYC - 1'b1) begin
          r_next.cnt   = '0;
          r_next.start = 1'b1;
          r_next.tx    = frame_byte(r_reg.op_read, r_reg.frame, 2'd0, r_reg.addr, r_reg.wdata);
          r_next.idx   = 2'd0;
          r_next.state = ST_XFER;
        end else begin
          r_next.cnt = r_reg.cnt + 1'b1;
        end
      end

      ST_XFER: begin
        if (sh_done) begin
          if (!r_reg.frame) begin
            if (!r_reg.op_read) begin
              // Write enable sent; cycle select to latch it (R6)
              r_next.selected = 1'b0;
              r_next.cnt      = '0;
              r_next.state    = ST_DESEL;
            end else if (r_reg.idx == 2'd0) begin
              // Status byte follows the command directly (R15)
              r_next.idx   = 2'd1;
              r_next.start = 1'b1;
              r_next.tx    = DUMMY_BYTE;
            end else if (sh_rx[STATUS_BUSY_BIT]) begin
              // Write cycle still running: read status again (R10)
              r_next.start = 1'b1;
              r_next.tx    = DUMMY_BYTE;
            end else begin
              // Polling complete: cycle select (R11)
              r_next.selected = 1'b0;
              r_next.cnt      = '0;
              r_next.state    = ST_DESEL;
            end
          end else if (r_reg.idx != 2'd3) begin
            // Opcode, address high, address low, data in one frame (R7) (R11)
            r_next.idx   = r_reg.idx + 2'd1;
            r_next.start = 1'b1;
            r_next.tx    = frame_byte(r_reg.op_read, 1'b1, r_reg.idx + 2'd1, r_reg.addr, r_reg.wdata);
          end else begin
            if (r_reg.op_read) begin
              r_next.buf_data = sh_rx; // (R16)
            end
            // Rising select ends the frame and, for a write, starts the write cycle (R8)
            r_next.selected = 1'b0;
            r_next.cnt      = '0;
            r_next.state    = ST_DESEL;
          end
        end
      end

      ST_DESEL: begin
        if (r_reg.cnt == CS_GAP_CYC - 1'b1) begin
          r_next.cnt = '0;
          if (!r_reg.frame) begin
            r_next.frame    = 1'b1;
            r_next.idx      = 2'd0;
            r_next.selected = 1'b1;
            r_next.state    = ST_SEL;
          end else if (r_reg.op_read) begin
            r_next.state = ST_ARM_BUF;
          end else begin
            r_next.done  = 1'b1;
            r_next.state = ST_IDLE;
          end
        end else begin
          r_next.cnt = r_reg.cnt + 1'b1;
        end
      end

      ST_ARM_BUF: begin
        // Read byte into the first buffer location (R12)
        r_next.buf_we = 1'b1;
        r_next.state  = ST_ARM_HI;
      end

      ST_ARM_HI: begin
        // High count byte first, it does not arm (R12)
        r_next.cnt_data  = COUNT_HIGH_VAL;
        r_next.cnt_hi_we = 1'b1;
        r_next.state     = ST_ARM_LO;
      end

      ST_ARM_LO: begin
        // Low count byte of one arms the transfer (R12)
        r_next.cnt_data  = COUNT_LOW_VAL;
        r_next.cnt_lo_we = 1'b1;
        r_next.done      = 1'b1;
        r_next.state     = ST_IDLE;
      end

      default: begin
        r_next.selected = 1'b0;
        r_next.state    = ST_IDLE;
      end
    endcase

    // One select per slave, only the chosen one goes low (R5) (R2)
    for (int i = 0; i < SLAVE_COUNT; i++) begin
      r_next.cs_n[i] = !(r_next.selected && (r_next.slave == 1'(i)));
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      r_reg       <= '0;
      r_reg.state <= ST_IDLE;
      r_reg.cs_n  <= '1;
    end else begin
      r_reg <= r_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign busy                  = (r_reg.state != ST_IDLE);
  assign done                  = r_reg.done;
  assign control_in_buffer     = r_reg.buf_data;
  assign control_in_buffer_we  = r_reg.buf_we;
  assign control_count_data    = r_reg.cnt_data;
  assign control_count_high_we = r_reg.cnt_hi_we;
  assign control_count_low_we  = r_reg.cnt_lo_we;
  assign spi_cs_n              = r_reg.cs_n;

endmodule
`default_nettype wire

// file: rtl/sea_pkg.sv
// Constants and types shared by the serial EEPROM access master
package sea_pkg;

  // ----------------------------------------------------------------
  // Clock and serial timing
  // ----------------------------------------------------------------
  localparam int CLK_FREQ_MHZ = 125;
  // Least half period of the serial clock, in ns
  localparam int SCLK_HALF_NS = 500;
  // Rounded up to whole clock cycles
  localparam int SCLK_HALF_CYC_INT = (SCLK_HALF_NS * CLK_FREQ_MHZ + 999) / 1000;
  localparam int CNT_W = 7;
  localparam logic [CNT_W-1:0] SCLK_HALF_CYC = CNT_W'(SCLK_HALF_CYC_INT);
  // Select setup and deselect gap, in clock cycles
  localparam logic [CNT_W-1:0] CS_GAP_CYC = CNT_W'(SCLK_HALF_CYC_INT);

  // ----------------------------------------------------------------
  // Byte framing
  // ----------------------------------------------------------------
  localparam int BITS_PER_BYTE = 8;
  localparam logic [3:0] LAST_PHASE = 4'(2 * BITS_PER_BYTE - 1);

  // ----------------------------------------------------------------
  // EEPROM commands
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_WRITE        = 8'h02;
  localparam logic [7:0] OP_READ_STATUS  = 8'h05;
  localparam logic [7:0] OP_READ         = 8'h03;
  localparam logic [7:0] DUMMY_BYTE      = 8'h00;
  localparam int         STATUS_BUSY_BIT = 0;

  // ----------------------------------------------------------------
  // Setup packet layout and memory geometry
  // ----------------------------------------------------------------
  localparam int SETUP_BYTES       = 8;
  localparam int SETUP_ADDR_LO_IDX = 2;
  localparam int SETUP_ADDR_HI_IDX = 3;
  localparam int SETUP_DATA_IDX    = 4;
  localparam int ARRAY_ADDR_W      = 11;
  localparam int SLAVE_COUNT       = 2;

  // ----------------------------------------------------------------
  // Control-IN arming values
  // ----------------------------------------------------------------
  localparam logic [7:0] COUNT_HIGH_VAL = 8'h00;
  localparam logic [7:0] COUNT_LOW_VAL  = 8'h01;

  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SEL,
    ST_XFER,
    ST_DESEL,
    ST_ARM_BUF,
    ST_ARM_HI,
    ST_ARM_LO
  } sea_state_e;

endpackage

// file: rtl/sea_shift.sv
// One-byte serial shifter, modes (0,0) and (1,1), MSB first
`timescale 1ns/1ps
`default_nettype none
module sea_shift
  import sea_pkg::*;
(
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       sys_rst,
  // Byte request
  input  wire logic       start,
  input  wire logic [7:0] tx_byte,
  input  wire logic       cpol,
  // Synchronised serial input
  input  wire logic       miso_sync,
  // Serial outputs
  output logic            sclk,
  output logic            mosi,
  // Result
  output logic [7:0]      rx_byte,
  output logic            done
);

  typedef struct packed {
    logic             busy;
    logic [3:0]       phase;
    logic [CNT_W-1:0] cnt;
    logic [7:0]       tx;
    logic [7:0]       rx;
    logic             sclk;
    logic             mosi;
    logic             done;
  } sea_shift_s;

  sea_shift_s r_reg;
  sea_shift_s r_next;

  always_comb begin
    r_next      = r_reg;
    r_next.done = 1'b0;
    if (!r_reg.busy) begin
      // Idle level follows the selected mode (R4)
      r_next.sclk = cpol;
      if (start) begin
        r_next.busy  = 1'b1;
        r_next.phase = 4'h0;
        r_next.cnt   = '0;
        r_next.tx    = tx_byte;
        r_next.mosi  = tx_byte[7]; // (R1)
        r_next.sclk  = 1'b0;
      end
    end else if (r_reg.cnt == SCLK_HALF_CYC - 1'b1) begin
      r_next.cnt   = '0;
      r_next.phase = r_reg.phase + 4'h1;
      if (!r_reg.phase[0]) begin
        r_next.sclk = 1'b1;
      end else begin
        // Sample late in the high half; slave changes only after the fall (R4)
        r_next.rx = {r_reg.rx[6:0], miso_sync}; // (R1)
        if (r_reg.phase == LAST_PHASE) begin
          r_next.busy = 1'b0;
          r_next.done = 1'b1;
          r_next.sclk = cpol;
        end else begin
          r_next.sclk = 1'b0;
          r_next.tx   = {r_reg.tx[6:0], 1'b0};
          r_next.mosi = r_reg.tx[6]; // (R1)
        end
      end
    end else begin
      r_next.cnt = r_reg.cnt + 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign sclk    = r_reg.sclk;
  assign mosi    = r_reg.mosi;
  assign rx_byte = r_reg.rx;
  assign done    = r_reg.done;

endmodule
`default_nettype wire
